// ---- watchdog_and_interrupt_enable_test.sv ----
// Purpose: Self-checking bench for the watchdog and interrupt block.
// Assumes: Short tick and pulse counts stand in for the real ones.
// Notes:   Expected values come from a register model kept here.
`timescale 1ns/1ps
`default_nettype none
module watchdog_and_interrupt_enable_test;
  localparam logic [16:0] IRQ = wdie_pkg::WDIE_ADDR_IRQ_CTRL;
  localparam logic [16:0] WD  = wdie_pkg::WDIE_ADDR_WDOG;
  localparam logic [16:0] FLG = wdie_pkg::WDIE_ADDR_FLAGS;
  logic        ref_clk, rst_b, alarmMatch, powerFail, busDataOe, irqPinOut, irqPinOe;
  logic        chipEnable_b, writeEnable_b, outputEnable_b, guardM;
  logic [16:0] busAddr;
  logic [7:0]  busDataIn, busDataOut, ctrlM, flagsM;
  logic [5:0]  multM;
  logic [31:0] seed = 32'h0000ABF4;
  int          mismatches, cmp_count, cyc;
  wdie_watchdog_irq #(.TICK_CYCLES(20), .PULSE_CYCLES(50)) u_dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .busAddr(busAddr), .busDataIn(busDataIn), .busDataOut(busDataOut), .busDataOe(busDataOe),
    .chipEnable_b(chipEnable_b), .writeEnable_b(writeEnable_b), .outputEnable_b(outputEnable_b),
    .alarmMatch(alarmMatch), .powerFail(powerFail), .irqPinOut(irqPinOut), .irqPinOe(irqPinOe));
  wdie_host_model u_host (.ref_clk(ref_clk), .busAddr(busAddr), .busDataIn(busDataIn),
    .chipEnable_b(chipEnable_b), .writeEnable_b(writeEnable_b), .outputEnable_b(outputEnable_b),
    .busDataOut(busDataOut));
  // Clock and a cycle ceiling; the tests need about a thousand and fifty cycles.
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      final_report;
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("FAIL %0t got %h exp %h", $time, got, exp);
      mismatches++;
    end
  endtask
  // Writes update the model; the timeout only moves when the guard was already clear.
  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_host.access(a, 1'b1, d, q);
    if (a == IRQ) ctrlM = d & 8'hFC;
    if (a == WD && !guardM) multM = d[5:0];
    if (a == WD) guardM = d[6];
  endtask
  task automatic rd(input logic [16:0] a);
    logic [7:0] q;
    u_host.access(a, 1'b0, 8'h00, q);
    chk(q, a == IRQ ? ctrlM : a == WD ? {1'b0, guardM, multM} : flagsM);
    if (a == FLG) flagsM = 8'h00;
  endtask
  // The pin is active when driven at the level chosen by the polarity bit.
  task automatic pin(input logic e);
    chk({7'h00, irqPinOe === 1'b1 && irqPinOut === ctrlM[3]}, {7'h00, e});
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence.
  initial begin
    rst_b = 1'b0;
    alarmMatch = 1'b0;
    powerFail = 1'b0;
    ctrlM = 8'h08;
    multM = 6'h00;
    guardM = 1'b1;
    flagsM = 8'h00;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rd(IRQ);
    rd(WD);
    $display("test reset done");
    wr(WD, 8'h05);
    rd(WD);
    wr(WD, 8'h05);
    rd(WD);
    wr(WD, 8'hC5);
    rd(WD);
    $display("test guard done");
    wr(IRQ, 8'h88);
    wr(WD, 8'hC5);
    repeat (70) @(posedge ref_clk);
    pin(1'b0);
    wr(WD, 8'hC5);
    repeat (70) @(posedge ref_clk);
    pin(1'b0);
    repeat (40) @(posedge ref_clk);
    flagsM = 8'h80;
    pin(1'b1);
    rd(FLG);
    pin(1'b0);
    wr(WD, 8'h00);
    wr(WD, 8'h00);
    repeat (250) @(posedge ref_clk);
    rd(FLG);
    $display("test watchdog done");
    // Level mode must still hold the pin after the pulse length; pulse mode must have let go.
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(IRQ, seed[7:0]);
      rd(IRQ);
      if (i[0]) alarmMatch <= 1'b1;
      else powerFail <= 1'b1;
      repeat (6) @(posedge ref_clk);
      pin(i[0] ? ctrlM[6] : ctrlM[5]);
      alarmMatch <= 1'b0;
      powerFail <= 1'b0;
      repeat (60) @(posedge ref_clk);
      pin(!ctrlM[2] && (i[0] ? ctrlM[6] : ctrlM[5]));
      flagsM = i[0] ? 8'h40 : 8'h20;
      rd(FLG);
      pin(1'b0);
    end
    $display("test events done");
    final_report;
  end
endmodule // watchdog_and_interrupt_enable_test
`default_nettype wire

// ---- wdie_checker_asserts.sv ----
// Purpose: Port-level checks of the watchdog and interrupt block.
// Assumes: The host holds address and data through each access.
// Notes:   Pin drive checks wait for an idle bus, as polarity writes land late; the flag-read check does not.
`timescale 1ns/1ps
`default_nettype none
module wdie_checker (
  // Clock and reset.
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // Host bus.
  input wire logic [16:0] busAddr,
  input wire logic [7:0]  busDataIn,
  input wire logic [7:0]  busDataOut,
  input wire logic        busDataOe,
  input wire logic        chipEnable_b,
  input wire logic        writeEnable_b,
  // Interrupt pin.
  input wire logic        irqPinOut,
  input wire logic        irqPinOe
);
  logic       hiPol_reg;
  logic [3:0] quiet_reg;
  logic       isFlags;
  logic       isWdog;
  logic       irqOn;
  // Address decodes and the pin seen as asserted at the shadowed polarity.
  assign isFlags = busAddr == wdie_pkg::WDIE_ADDR_FLAGS;
  assign isWdog  = busAddr == wdie_pkg::WDIE_ADDR_WDOG;
  assign irqOn   = irqPinOe && irqPinOut == hiPol_reg;
  // Shadow the polarity bit and count idle bus cycles since the last access.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hiPol_reg <= 1'b1;
      quiet_reg <= 4'h0;
    end else begin
      if (!chipEnable_b && !writeEnable_b && busAddr == wdie_pkg::WDIE_ADDR_IRQ_CTRL) hiPol_reg <= busDataIn[3];
      quiet_reg <= !chipEnable_b ? 4'h0 : quiet_reg + {3'h0, quiet_reg != 4'hF};
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_strobe_reads_zero: assert property (busDataOe && isWdog |-> !busDataOut[7])
    else $error("strobe bit read back as one");
  a_flag_low_zero: assert property (busDataOe && isFlags |-> busDataOut[4:0] == 5'h00)
    else $error("flag register low bits not zero");
  a_unmapped_quiet: assert property (busDataOe |-> busAddr inside {17'h1FFF0, 17'h1FFF6, 17'h1FFF7})
    else $error("data driven for unmapped address");
  a_oe_after_ce: assert property ($rose(busDataOe) |-> !$past(chipEnable_b, 2))
    else $error("data driven without chip enable");
  a_data_holds: assert property (busDataOe && $past(busDataOe) |-> $stable(busDataOut))
    else $error("read data changed during access");
  a_open_drain: assert property (quiet_reg == 4'hF && !hiPol_reg && irqPinOe |-> !irqPinOut)
    else $error("open-drain pin driven high");
  a_push_pull: assert property (quiet_reg == 4'hF && hiPol_reg |-> irqPinOe)
    else $error("push-pull pin not driven");
  a_read_ends_int: assert property ($rose(busDataOe) && isFlags |-> ##[1:3] !irqOn)
    else $error("interrupt still active after flag read");
  c_int_high: cover property ($rose(irqPinOe && irqPinOut));
  c_flag_read: cover property (busDataOe && isFlags && busDataOut[7]);
  c_open_drain: cover property (!hiPol_reg && irqPinOe);
endmodule // wdie_checker
bind wdie_watchdog_irq wdie_checker u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .busAddr(busAddr),
  .busDataIn(busDataIn), .busDataOut(busDataOut), .busDataOe(busDataOe), .chipEnable_b(chipEnable_b),
  .writeEnable_b(writeEnable_b), .irqPinOut(irqPinOut), .irqPinOe(irqPinOe));
`default_nettype wire

// ---- wdie_host_model.sv ----
// Purpose: Host bus master for the watchdog block.
// Assumes: Device pins pass two flip-flops before use.
// Notes:   Released data lines show the inverse, never a stale value.
`timescale 1ns/1ps
`default_nettype none
module wdie_host_model (
  // Clock.
  input  wire logic        ref_clk,
  // Bus pins.
  output var  logic [16:0] busAddr,
  output var  logic [7:0]  busDataIn,
  output var  logic        chipEnable_b,
  output var  logic        writeEnable_b,
  output var  logic        outputEnable_b,
  input  wire logic [7:0]  busDataOut
);
  // Idle bus at time zero.
  initial begin
    busAddr = 17'h00000;
    busDataIn = 8'h00;
    chipEnable_b = 1'b1;
    writeEnable_b = 1'b1;
    outputEnable_b = 1'b1;
  end
  // Setup three clocks before select, hold through the answer, then a gap of four.
  task automatic access(input logic [16:0] a, input logic wr, input logic [7:0] d, output logic [7:0] q);
    busAddr <= a;
    busDataIn <= d;
    writeEnable_b <= !wr;
    outputEnable_b <= wr;
    repeat (3) @(posedge ref_clk);
    chipEnable_b <= 1'b0;
    repeat (6) @(posedge ref_clk);
    q = busDataOut;
    chipEnable_b <= 1'b1;
    busDataIn <= ~d;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule // wdie_host_model
`default_nettype wire

// ---- wdie_pkg.sv ----
// Purpose: Shared constants for the watchdog and interrupt enable block.
// Assumes: Byte-wide register access at the printed addresses, 125 MHz ref_clk.
// Notes:   Timing counts are derived from times in their own units.
`default_nettype none
package wdie_pkg;

  // Register addresses on the 17-bit memory bus.
  localparam logic [16:0] WDIE_ADDR_IRQ_CTRL = 17'h1FFF6;
  localparam logic [16:0] WDIE_ADDR_WDOG     = 17'h1FFF7;
  localparam logic [16:0] WDIE_ADDR_FLAGS    = 17'h1FFF0;

  // Watchdog control field positions.
  localparam int WDIE_WDOG_STROBE_BIT = 7;
  localparam int WDIE_WDOG_GUARD_BIT  = 6;
  localparam int WDIE_WDOG_MULT_MSB   = 5;

  // Interrupt routing control field positions.
  localparam int WDIE_IRQ_WDOG_BIT   = 7;
  localparam int WDIE_IRQ_ALARM_BIT  = 6;
  localparam int WDIE_IRQ_PFAIL_BIT  = 5;
  localparam int WDIE_IRQ_BACKUP_BIT = 4;
  localparam int WDIE_IRQ_HIGH_BIT   = 3;
  localparam int WDIE_IRQ_PULSE_BIT  = 2;

  // Flag register field positions.
  localparam int WDIE_FLAG_WDOG_BIT  = 7;
  localparam int WDIE_FLAG_ALARM_BIT = 6;
  localparam int WDIE_FLAG_PFAIL_BIT = 5;

  // Reset values.
  localparam logic [7:0] WDIE_IRQ_CTRL_RESET = 8'h08;
  localparam logic [5:0] WDIE_MULT_RESET     = 6'h00;
  localparam logic       WDIE_GUARD_RESET    = 1'b1;

  // Timing: clock rate, tick period and interrupt pulse width.
  localparam longint WDIE_CLK_HZ       = 125000000;
  localparam longint WDIE_TICK_HZ      = 32;
  localparam longint WDIE_PULSE_MS     = 200;
  localparam longint WDIE_TICK_CYCLES  = WDIE_CLK_HZ / WDIE_TICK_HZ;
  localparam longint WDIE_PULSE_CYCLES = (WDIE_CLK_HZ / 1000) * WDIE_PULSE_MS;

endpackage
`default_nettype wire

// ---- wdie_sync.sv ----
// Purpose: Two flip-flop synchroniser for a vector of asynchronous levels.
// Assumes: Each bit is an independent level.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ps
`default_nettype none
module wdie_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  // Levels.
  input  wire logic [WIDTH-1:0] asyncIn,
  output var  logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1Reg;

  // Two stages to settle metastability.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1Reg <= '0;
      syncOut   <= '0;
    end else begin
      stage1Reg <= asyncIn;
      syncOut   <= stage1Reg;
    end
  end

endmodule // wdie_sync
`default_nettype wire

// ---- wdie_watchdog_irq.sv ----
// Purpose: Watchdog control and interrupt routing registers with the INT pin driver.
// Assumes: Host bus pins are asynchronous and are synchronised before use.
// Notes:   A bus access takes effect once per chip-enable assertion.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RULE1] Writing strobe bit 1 reloads the watchdog counter and restarts it.
// [RULE2] Strobe bit clears itself once the counter has been reloaded.
// [RULE3] Strobe bit is write-only and always reads zero.
// [RULE4] Timeout is a 6-bit field in the low bits of watchdog control.
// [RULE5] Timeout counts multiples of the 32 Hz tick, 1 to 63 ticks.
// [RULE6] Timeout value zero disables the watchdog completely.
// [RULE7] Timeout writes are accepted only after the guard was cleared earlier.
// [RULE8] Alarm match sets its flag; interrupt only when alarm enable is 1.
// [RULE9] Power failure sets its flag; interrupt only when power-fail enable is 1.
// [RULE10] Watchdog timeout sets its flag; interrupt only when watchdog enable is 1.
// [RULE11] Polarity 1 gives active-high push-pull, 0 gives active-low open-drain.
// [RULE12] Pulse mode drives about 200 ms; level mode holds until flags read.
// [RULE13] Reading flags returns the three flags and then clears them.
// [RULE14] Host strobes the watchdog before the programmed tick count elapses.
module wdie_watchdog_irq #(
  parameter longint TICK_CYCLES  = wdie_pkg::WDIE_TICK_CYCLES,
  parameter longint PULSE_CYCLES = wdie_pkg::WDIE_PULSE_CYCLES
) (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // Host memory bus pins.
  input  wire logic [16:0] busAddr,
  input  wire logic [7:0]  busDataIn,
  output var  logic [7:0]  busDataOut,
  output var  logic        busDataOe,
  input  wire logic        chipEnable_b,
  input  wire logic        writeEnable_b,
  input  wire logic        outputEnable_b,
  // Event sources from the clock and power monitor.
  input  wire logic        alarmMatch,
  input  wire logic        powerFail,
  // Interrupt pin.
  output var  logic        irqPinOut,
  output var  logic        irqPinOe
);

  logic [7:0]  irqCtrl_reg;
  logic [5:0]  mult_reg;
  logic        guard_reg;
  logic [5:0]  wdogCount_reg;
  logic [26:0] tickCount_reg;
  logic [7:0]  flags_reg;
  logic        irqActive_reg;
  logic [31:0] pulseCount_reg;
  logic [7:0]  dataSync;
  logic [16:0] addrSync;
  logic [2:0]  ctlSync;
  logic [1:0]  evtSync;
  logic        accessDone_reg;
  logic        alarmPrev_reg;
  logic        pfailPrev_reg;
  logic        accessGo;
  logic        writeGo;
  logic        readGo;
  logic        wdogSel;
  logic        irqSel;
  logic        flagSel;
  logic        strobe;
  logic        tickEvt;
  logic        wdogTimeout;
  logic        alarmEvt;
  logic        pfailEvt;
  logic        irqFire;
  logic        flagRead;

  // Bus pins are asynchronous to ref_clk, so every one is synchronised.
  wdie_sync #(.WIDTH(28)) busSync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .asyncIn ({busAddr, busDataIn, chipEnable_b, writeEnable_b, outputEnable_b}),
    .syncOut ({addrSync, dataSync, ctlSync})
  );

  // Event levels come from other circuits and are synchronised too.
  wdie_sync #(.WIDTH(2)) evtSyncInst (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .asyncIn ({alarmMatch, powerFail}),
    .syncOut (evtSync)
  );

  // One action per chip-enable assertion; address and data settle first.
  assign accessGo = !ctlSync[2] && !accessDone_reg;
  assign writeGo  = accessGo && !ctlSync[1];
  assign readGo   = accessGo && ctlSync[1] && !ctlSync[0];
  assign wdogSel  = (addrSync == wdie_pkg::WDIE_ADDR_WDOG);
  assign irqSel   = (addrSync == wdie_pkg::WDIE_ADDR_IRQ_CTRL);
  assign flagSel  = (addrSync == wdie_pkg::WDIE_ADDR_FLAGS);
  assign strobe   = writeGo && wdogSel && dataSync[wdie_pkg::WDIE_WDOG_STROBE_BIT];
  assign flagRead = readGo && flagSel;

  // Access latch is released when chip enable returns high.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      accessDone_reg <= 1'b0;
    end else begin
      accessDone_reg <= !ctlSync[2];
    end
  end

  // Watchdog control register; the strobe is not stored so it reads zero.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mult_reg  <= wdie_pkg::WDIE_MULT_RESET;
      guard_reg <= wdie_pkg::WDIE_GUARD_RESET;
    end else if (writeGo && wdogSel) begin
      guard_reg <= dataSync[wdie_pkg::WDIE_WDOG_GUARD_BIT];
      if (!guard_reg) begin // [RULE7]
        mult_reg <= dataSync[wdie_pkg::WDIE_WDOG_MULT_MSB:0]; // [RULE4]
      end
    end
  end

  // Interrupt routing register, low two bits reserved.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqCtrl_reg <= wdie_pkg::WDIE_IRQ_CTRL_RESET;
    end else if (writeGo && irqSel) begin
      irqCtrl_reg <= {dataSync[7:2], 2'b00};
    end
  end

  // Free-running 32 Hz tick prescaler; a strobe realigns it.
  assign tickEvt = (tickCount_reg == 27'(TICK_CYCLES - 1));
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tickCount_reg <= '0;
    end else if (strobe || tickEvt) begin
      tickCount_reg <= '0; // [RULE1]
    end else begin
      tickCount_reg <= tickCount_reg + 27'h0000001;
    end
  end

  // Down counter of ticks; reload on strobe or timeout, never times out while the multiplier is zero.
  // The strobe acts in one cycle, so nothing needs clearing afterwards.
  assign wdogTimeout = (mult_reg != 6'h00) && tickEvt && (wdogCount_reg == 6'h01); // [RULE6]
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wdogCount_reg <= '0;
    end else if (strobe || wdogTimeout) begin
      wdogCount_reg <= mult_reg; // [RULE1] [RULE2] [RULE5]
    end else if (tickEvt && wdogCount_reg > 6'h01) begin
      wdogCount_reg <= wdogCount_reg - 6'h01; // [RULE5]
    end
  end

  // Rising edges of the event levels.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      alarmPrev_reg <= 1'b0;
      pfailPrev_reg <= 1'b0;
    end else begin
      alarmPrev_reg <= evtSync[1];
      pfailPrev_reg <= evtSync[0];
    end
  end
  assign alarmEvt = evtSync[1] && !alarmPrev_reg;
  assign pfailEvt = evtSync[0] && !pfailPrev_reg;

  // Flags set on events and clear on read; a new event wins over the clear.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_reg <= 8'h00;
    end else begin
      if (flagRead) begin
        flags_reg <= 8'h00; // [RULE13]
      end
      if (wdogTimeout) begin
        flags_reg[wdie_pkg::WDIE_FLAG_WDOG_BIT] <= 1'b1; // [RULE10]
      end
      if (alarmEvt) begin
        flags_reg[wdie_pkg::WDIE_FLAG_ALARM_BIT] <= 1'b1; // [RULE8]
      end
      if (pfailEvt) begin
        flags_reg[wdie_pkg::WDIE_FLAG_PFAIL_BIT] <= 1'b1; // [RULE9]
      end
    end
  end

  // Only enabled sources reach the interrupt pin.
  assign irqFire = (wdogTimeout && irqCtrl_reg[wdie_pkg::WDIE_IRQ_WDOG_BIT]) // [RULE10]
                || (alarmEvt && irqCtrl_reg[wdie_pkg::WDIE_IRQ_ALARM_BIT])   // [RULE8]
                || (pfailEvt && irqCtrl_reg[wdie_pkg::WDIE_IRQ_PFAIL_BIT]);  // [RULE9]

  // Interrupt assertion: pulse mode times out, both modes end on a flag read.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqActive_reg  <= 1'b0;
      pulseCount_reg <= '0;
    end else if (irqFire) begin
      irqActive_reg  <= 1'b1;
      pulseCount_reg <= 32'(PULSE_CYCLES - 1);
    end else if (flagRead) begin
      irqActive_reg <= 1'b0; // [RULE12]
    end else if (irqActive_reg && irqCtrl_reg[wdie_pkg::WDIE_IRQ_PULSE_BIT]) begin
      if (pulseCount_reg == 32'h00000000) begin
        irqActive_reg <= 1'b0; // [RULE12]
      end else begin
        pulseCount_reg <= pulseCount_reg - 32'h00000001;
      end
    end
  end

  // Pin driver: push-pull active high, or open-drain pulling low.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqPinOut <= 1'b0;
      irqPinOe  <= 1'b0;
    end else if (irqCtrl_reg[wdie_pkg::WDIE_IRQ_HIGH_BIT]) begin
      irqPinOut <= irqActive_reg; // [RULE11]
      irqPinOe  <= 1'b1;
    end else begin
      irqPinOut <= 1'b0; // [RULE11]
      irqPinOe  <= irqActive_reg;
    end
  end

  // Read data; other addresses belong to other blocks and are not driven.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busDataOut <= 8'h00;
      busDataOe  <= 1'b0;
    end else begin
      busDataOe <= !ctlSync[2] && ctlSync[1] && !ctlSync[0] && (wdogSel || irqSel || flagSel);
      if (readGo && wdogSel) begin
        busDataOut <= {1'b0, guard_reg, mult_reg}; // [RULE3]
      end else if (readGo && irqSel) begin
        busDataOut <= irqCtrl_reg;
      end else if (flagRead) begin
        busDataOut <= {flags_reg[7:5], 5'h00}; // [RULE13]
      end
    end
  end

endmodule // wdie_watchdog_irq
`default_nettype wire
